// *** hw/pdc_defs.vh ***
// pdc_defs.vh: offsets, field positions, reset values and codes of the pointer decoder register bank
`ifndef PDC_DEFS_VH
`define PDC_DEFS_VH

// ****************************************
// pointer byte fields
// ****************************************
`define PDC_PTR_MODE_HI 7
`define PDC_PTR_MODE_LO 4
`define PDC_PTR_SEL_HI 3
`define PDC_PTR_SEL_LO 0

// ****************************************
// mode codes
// ****************************************
`define PDC_MODE_CONFIG 4'h0
`define PDC_MODE_DAC_WRITE 4'h1
`define PDC_MODE_ADC_READ 4'h4
`define PDC_MODE_DAC_READ 4'h5
`define PDC_MODE_GPIO_READ 4'h6
`define PDC_MODE_REG_READ 4'h7

// ****************************************
// configuration register offsets
// ****************************************
`define PDC_OFS_NO_OPERATION 4'h0
`define PDC_OFS_CURRENT_BOOST 4'h1
`define PDC_OFS_ADC_SEQUENCE 4'h2
`define PDC_OFS_GENERAL_CONTROL 4'h3
`define PDC_OFS_ADC_PIN_SELECT 4'h4
`define PDC_OFS_VOLTAGE_OUT_PIN_SELECT 4'h5
`define PDC_OFS_PULLDOWN_PIN_SELECT 4'h6
`define PDC_OFS_DAC_LOAD_MODE 4'h7
`define PDC_OFS_DIGITAL_OUT_PIN_SELECT 4'h8
`define PDC_OFS_DIGITAL_OUT_DATA 4'h9
`define PDC_OFS_DIGITAL_IN_PIN_SELECT 4'hA
`define PDC_OFS_POWERDOWN_REFERENCE_CTRL 4'hB
`define PDC_OFS_OPEN_DRAIN_PIN_SELECT 4'hC
`define PDC_OFS_HIGH_IMPEDANCE_PIN_SELECT 4'hD
`define PDC_OFS_CURRENT_OUT_PIN_SELECT 4'hE
`define PDC_OFS_SOFT_RESET 4'hF

// ****************************************
// reset values
// ****************************************
`define PDC_RST_ZERO 16'h0000
`define PDC_RST_PULLDOWN 16'h00FF

// ****************************************
// field positions and masks
// ****************************************
`define PDC_BOOST_HI 8
`define PDC_BOOST_LO 5
`define PDC_BOOST_MASK 16'h01E0
`define PDC_GC_MASK 16'h02F0
`define PDC_PIN_MASK 16'h00FF
`define PDC_PIN_REG_SET 16'h7570
`define PDC_GC_ADC_BUFFER 9
`define PDC_GC_LOCK 7
`define PDC_GC_BROADCAST 6
`define PDC_GC_ADC_RANGE 5
`define PDC_GC_DAC_RANGE 4
`define PDC_DAC_CH_HI 2
`define PDC_LOAD_DIRECT 2'h0
`define PDC_LOAD_HOLD 2'h1
`define PDC_LOAD_TRANSFER 2'h2

`endif

// *** hw/pdc_pointer_decode_config_regs.v ***
// pdc_pointer_decode_config_regs.v: pointer byte decoder and configuration register bank
// Functional notes
// [R1] first data byte of a write is pointer
// [R2] pointer high nibble mode, low nibble selector
// [R3] decode six mode codes, others unused
// [R4] sixteen config registers; 0 nop, 15 reset
// [R5] all clear at reset except pull-down 0x00FF
// [R6] boost bits 8..5 for current channels 3..0
// [R7] host writes zeros to reserved bits
// [R8] control bit 9 enables ADC auxiliary buffer
// [R9] control bit 7 locks pin config registers
// [R10] control bit 6 broadcasts DAC writes
// [R11] control bit 5 selects ADC range
// [R12] control bit 4 selects voltage DAC range
// [R13] pin register bit n maps pin n
// [R14] current output only on pins 0..3
// [R15] bit one enables function on pin
// [R16] after power-up all pins pulled down
// [R17] DAC drives pin, ADC may still convert
// [R18] software reset equals hardware reset
// [R19] load mode field bits 1:0 decoded
// [R20] DAC write pointer bits 2..0 select channel
// [R21] two data bytes, MSB first, form word
// [R22] register updates only after both bytes
`timescale 1ns/1ns
`include "pdc_defs.vh"

module pdc_pointer_decode_config_regs
(
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire frame_start_in,
    input wire byte_valid_in,
    input wire [7:0] byte_data_in,
    output reg [3:0] ptr_mode_out,
    output reg [3:0] ptr_sel_out,
    output reg ptr_valid_out,
    output wire mode_unused_out,
    output wire mode_adc_read_out,
    output wire mode_dac_read_out,
    output wire mode_gpio_read_out,
    output wire mode_reg_read_out,
    output reg [15:0] reg_read_data_out,
    output reg dac_write_out,
    output reg [7:0] dac_write_mask_out,
    output reg [15:0] dac_write_data_out,
    output reg dac_transfer_out,
    output wire dac_load_direct_out,
    output wire dac_load_hold_out,
    output reg soft_reset_out,
    output wire [3:0] current_boost_out,
    output wire [15:0] adc_sequence_out,
    output wire adc_buffer_en_out,
    output wire adc_range_double_out,
    output wire dac_range_double_out,
    output wire [15:0] powerdown_reference_out,
    output wire [7:0] pin_adc_en_out,
    output wire [7:0] pin_voltage_out_en_out,
    output wire [7:0] pin_current_out_en_out,
    output wire [7:0] pin_dac_drive_out,
    output wire [7:0] pin_pulldown_en_out,
    output wire [7:0] pin_digital_out_en_out,
    output wire [7:0] pin_digital_out_data_out,
    output wire [7:0] pin_digital_in_en_out,
    output wire [7:0] pin_open_drain_out,
    output wire [7:0] pin_high_impedance_out
);

    // ****************************************
    // byte sequencer
    // ****************************************
    localparam ST_POINTER = 2'b00;
    localparam ST_MSB = 2'b01;
    localparam ST_LSB = 2'b10;

    reg [1:0] state;
    reg [1:0] next_state;
    reg [7:0] msb_hold;
    reg [15:0] cur_boost;
    reg [15:0] adc_seq;
    reg [15:0] gen_ctrl;
    reg [15:0] adc_pins;
    reg [15:0] vout_pins;
    reg [15:0] pd_pins;
    reg [15:0] load_mode;
    reg [15:0] dout_pins;
    reg [15:0] dout_data;
    reg [15:0] din_pins;
    reg [15:0] pwr_ref;
    reg [15:0] od_pins;
    reg [15:0] hiz_pins;
    reg [15:0] iout_pins;

    wire word_done;
    wire [15:0] word;
    wire cfg_write;
    wire pin_reg_sel;
    wire locked;
    wire soft_clear;

    always @*
    begin
        next_state = state;
        case (state)
            ST_POINTER:
            begin
                if (byte_valid_in)
                    next_state = ST_MSB;
            end
            ST_MSB:
            begin
                if (byte_valid_in)
                    next_state = ST_LSB;
            end
            ST_LSB:
            begin
                // further bytes repeat whole words to the same pointer
                if (byte_valid_in)
                    next_state = ST_MSB;
            end
            default:
            begin
                next_state = ST_POINTER;
            end
        endcase
    end

    // a frame restart drops a half word
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            state <= ST_POINTER;
        else if (frame_start_in || soft_clear)
            state <= ST_POINTER; // [R22] [R1]
        else
            state <= next_state;
    end

    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            msb_hold <= 8'h00;
        else if (byte_valid_in && state == ST_MSB)
            msb_hold <= byte_data_in; // [R21]
    end

    assign word_done = byte_valid_in && state == ST_LSB && !frame_start_in; // [R22]
    assign word = {msb_hold, byte_data_in}; // [R21]

    // ****************************************
    // pointer decode
    // ****************************************
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ptr_mode_out <= 4'h0;
            ptr_sel_out <= 4'h0;
            ptr_valid_out <= 1'b0;
        end
        else if (soft_clear)
        begin
            ptr_mode_out <= 4'h0;
            ptr_sel_out <= 4'h0;
            ptr_valid_out <= 1'b0;
        end
        else if (byte_valid_in && state == ST_POINTER && !frame_start_in)
        begin
            ptr_mode_out <= byte_data_in[`PDC_PTR_MODE_HI:`PDC_PTR_MODE_LO]; // [R1] [R2]
            ptr_sel_out <= byte_data_in[`PDC_PTR_SEL_HI:`PDC_PTR_SEL_LO]; // [R2]
            ptr_valid_out <= 1'b1;
        end
    end

    assign mode_adc_read_out = ptr_valid_out && ptr_mode_out == `PDC_MODE_ADC_READ; // [R3]
    assign mode_dac_read_out = ptr_valid_out && ptr_mode_out == `PDC_MODE_DAC_READ; // [R3]
    assign mode_gpio_read_out = ptr_valid_out && ptr_mode_out == `PDC_MODE_GPIO_READ; // [R3]
    assign mode_reg_read_out = ptr_valid_out && ptr_mode_out == `PDC_MODE_REG_READ; // [R3]
    assign mode_unused_out = ptr_valid_out && !(ptr_mode_out == `PDC_MODE_CONFIG ||
        ptr_mode_out == `PDC_MODE_DAC_WRITE || mode_adc_read_out || mode_dac_read_out ||
        mode_gpio_read_out || mode_reg_read_out); // [R3]

    // ****************************************
    // configuration writes
    // ****************************************
    assign cfg_write = word_done && ptr_mode_out == `PDC_MODE_CONFIG; // [R4]
    localparam [15:0] PIN_REGS = `PDC_PIN_REG_SET;
    assign pin_reg_sel = PIN_REGS[ptr_sel_out];
    assign locked = gen_ctrl[`PDC_GC_LOCK] && pin_reg_sel; // [R9]

    // clear lands a cycle late so the reset word completes
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            soft_reset_out <= 1'b0;
        else
            soft_reset_out <= cfg_write && ptr_sel_out == `PDC_OFS_SOFT_RESET; // [R4] [R18]
    end

    assign soft_clear = soft_reset_out; // [R18]

    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cur_boost <= `PDC_RST_ZERO; // [R5]
            adc_seq <= `PDC_RST_ZERO;
            gen_ctrl <= `PDC_RST_ZERO; // [R8]
            adc_pins <= `PDC_RST_ZERO;
            vout_pins <= `PDC_RST_ZERO;
            pd_pins <= `PDC_RST_PULLDOWN; // [R5] [R16]
            load_mode <= `PDC_RST_ZERO;
            dout_pins <= `PDC_RST_ZERO;
            dout_data <= `PDC_RST_ZERO;
            din_pins <= `PDC_RST_ZERO;
            pwr_ref <= `PDC_RST_ZERO;
            od_pins <= `PDC_RST_ZERO;
            hiz_pins <= `PDC_RST_ZERO;
            iout_pins <= `PDC_RST_ZERO;
        end
        else if (soft_clear)
        begin
            cur_boost <= `PDC_RST_ZERO; // [R18]
            adc_seq <= `PDC_RST_ZERO;
            gen_ctrl <= `PDC_RST_ZERO;
            adc_pins <= `PDC_RST_ZERO;
            vout_pins <= `PDC_RST_ZERO;
            pd_pins <= `PDC_RST_PULLDOWN; // [R18] [R16]
            load_mode <= `PDC_RST_ZERO;
            dout_pins <= `PDC_RST_ZERO;
            dout_data <= `PDC_RST_ZERO;
            din_pins <= `PDC_RST_ZERO;
            pwr_ref <= `PDC_RST_ZERO;
            od_pins <= `PDC_RST_ZERO;
            hiz_pins <= `PDC_RST_ZERO;
            iout_pins <= `PDC_RST_ZERO;
        end
        else if (cfg_write && !locked) // [R22] [R9]
        begin
            // reserved bits of boost, control and pin select registers are dropped and read as zero
            case (ptr_sel_out)
                `PDC_OFS_CURRENT_BOOST: cur_boost <= word & `PDC_BOOST_MASK; // [R6]
                `PDC_OFS_ADC_SEQUENCE: adc_seq <= word;
                `PDC_OFS_GENERAL_CONTROL: gen_ctrl <= word & `PDC_GC_MASK;
                `PDC_OFS_ADC_PIN_SELECT: adc_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_VOLTAGE_OUT_PIN_SELECT: vout_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_PULLDOWN_PIN_SELECT: pd_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_DAC_LOAD_MODE: load_mode <= word;
                `PDC_OFS_DIGITAL_OUT_PIN_SELECT: dout_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_DIGITAL_OUT_DATA: dout_data <= word;
                `PDC_OFS_DIGITAL_IN_PIN_SELECT: din_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_POWERDOWN_REFERENCE_CTRL: pwr_ref <= word;
                `PDC_OFS_OPEN_DRAIN_PIN_SELECT: od_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_HIGH_IMPEDANCE_PIN_SELECT: hiz_pins <= word & `PDC_PIN_MASK; // [R13]
                `PDC_OFS_CURRENT_OUT_PIN_SELECT: iout_pins <= word & `PDC_PIN_MASK; // [R13]
                default:
                begin
                    // no operation and software reset store nothing
                    cur_boost <= cur_boost; // [R4]
                end
            endcase
        end
    end

    // ****************************************
    // register readback
    // ****************************************
    always @*
    begin
        case (ptr_sel_out)
            `PDC_OFS_CURRENT_BOOST: reg_read_data_out = cur_boost;
            `PDC_OFS_ADC_SEQUENCE: reg_read_data_out = adc_seq;
            `PDC_OFS_GENERAL_CONTROL: reg_read_data_out = gen_ctrl;
            `PDC_OFS_ADC_PIN_SELECT: reg_read_data_out = adc_pins;
            `PDC_OFS_VOLTAGE_OUT_PIN_SELECT: reg_read_data_out = vout_pins;
            `PDC_OFS_PULLDOWN_PIN_SELECT: reg_read_data_out = pd_pins;
            `PDC_OFS_DAC_LOAD_MODE: reg_read_data_out = load_mode;
            `PDC_OFS_DIGITAL_OUT_PIN_SELECT: reg_read_data_out = dout_pins;
            `PDC_OFS_DIGITAL_OUT_DATA: reg_read_data_out = dout_data;
            `PDC_OFS_DIGITAL_IN_PIN_SELECT: reg_read_data_out = din_pins;
            `PDC_OFS_POWERDOWN_REFERENCE_CTRL: reg_read_data_out = pwr_ref;
            `PDC_OFS_OPEN_DRAIN_PIN_SELECT: reg_read_data_out = od_pins;
            `PDC_OFS_HIGH_IMPEDANCE_PIN_SELECT: reg_read_data_out = hiz_pins;
            `PDC_OFS_CURRENT_OUT_PIN_SELECT: reg_read_data_out = iout_pins;
            default: reg_read_data_out = `PDC_RST_ZERO;
        endcase
    end

    // ****************************************
    // DAC write and load control
    // ****************************************
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            dac_write_out <= 1'b0;
            dac_write_mask_out <= 8'h00;
            dac_write_data_out <= 16'h0000;
        end
        else if (soft_clear)
        begin
            dac_write_out <= 1'b0;
            dac_write_mask_out <= 8'h00;
            dac_write_data_out <= 16'h0000;
        end
        else
        begin
            dac_write_out <= word_done && ptr_mode_out == `PDC_MODE_DAC_WRITE;
            if (word_done && ptr_mode_out == `PDC_MODE_DAC_WRITE)
            begin
                dac_write_data_out <= word; // [R21]
                if (gen_ctrl[`PDC_GC_BROADCAST])
                    dac_write_mask_out <= 8'hFF; // [R10]
                else
                    dac_write_mask_out <= 8'h01 << ptr_sel_out[`PDC_DAC_CH_HI:0]; // [R20]
            end
        end
    end

    // the transfer code moves all held inputs at once
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
            dac_transfer_out <= 1'b0;
        else
            dac_transfer_out <= cfg_write && ptr_sel_out == `PDC_OFS_DAC_LOAD_MODE &&
                word[1:0] == `PDC_LOAD_TRANSFER; // [R19]
    end

    // reserved code: neither direct nor hold
    assign dac_load_direct_out = load_mode[1:0] == `PDC_LOAD_DIRECT; // [R19]
    assign dac_load_hold_out = load_mode[1:0] == `PDC_LOAD_HOLD; // [R19]

    // ****************************************
    // control fields
    // ****************************************
    assign current_boost_out = cur_boost[`PDC_BOOST_HI:`PDC_BOOST_LO] & iout_pins[3:0]; // [R6] [R14]
    assign adc_sequence_out = adc_seq;
    assign adc_buffer_en_out = gen_ctrl[`PDC_GC_ADC_BUFFER]; // [R8]
    assign adc_range_double_out = gen_ctrl[`PDC_GC_ADC_RANGE]; // [R11]
    assign dac_range_double_out = gen_ctrl[`PDC_GC_DAC_RANGE]; // [R12]
    assign powerdown_reference_out = pwr_ref;

    // ****************************************
    // per pin function enables
    // ****************************************
    genvar pin;
    generate
        for (pin = 0; pin < 8; pin = pin + 1)
        begin : g_pin
            wire drive;
            if (pin < 4)
            begin : g_cur
                assign pin_current_out_en_out[pin] = iout_pins[pin]; // [R14] [R15]
            end
            else
            begin : g_nocur
                assign pin_current_out_en_out[pin] = 1'b0; // [R14]
            end
            assign drive = vout_pins[pin] | pin_current_out_en_out[pin];
            assign pin_voltage_out_en_out[pin] = vout_pins[pin]; // [R15] [R13]
            assign pin_dac_drive_out[pin] = drive; // [R17]
            assign pin_adc_en_out[pin] = adc_pins[pin]; // [R17] [R15]
            // a driven pin drops its pull-down
            assign pin_pulldown_en_out[pin] = pd_pins[pin] & ~drive & ~dout_pins[pin]; // [R16] [R17]
            assign pin_digital_out_en_out[pin] = dout_pins[pin] & ~drive; // [R17] [R15]
            assign pin_digital_out_data_out[pin] = dout_data[pin]; // [R13]
            assign pin_digital_in_en_out[pin] = din_pins[pin]; // [R15]
            assign pin_open_drain_out[pin] = od_pins[pin]; // [R15]
            assign pin_high_impedance_out[pin] = hiz_pins[pin]; // [R15]
        end
    endgenerate

endmodule

// *** bench/pdc_host_model.sv ***
// host side byte feeder: frame starts and received write bytes
`timescale 1ns/1ns
module pdc_host_model
(
    input wire ref_clk_in,
    output reg frame_start_out = 1'b0,
    output reg byte_valid_out = 1'b0,
    output reg [7:0] byte_data_out = 8'h00
);
    // ****************************************
    // byte level tasks, all launched off the falling edge
    // ****************************************
    // data is inverted whenever no byte is offered, so a stale byte never looks valid
    task frame;
    begin
        @(negedge ref_clk_in);
        frame_start_out <= 1'b1;
        byte_valid_out <= 1'b0;
        byte_data_out <= ~byte_data_out;
    end
    endtask
    task put(input [7:0] b);
    begin
        @(negedge ref_clk_in);
        frame_start_out <= 1'b0;
        byte_valid_out <= 1'b1;
        byte_data_out <= b;
    end
    endtask
    task word(input [15:0] w);
    begin
        put(w[15:8]);
        put(w[7:0]);
    end
    endtask
    task idle(input integer n);
    begin
        repeat (n)
        begin
            @(negedge ref_clk_in);
            frame_start_out <= 1'b0;
            byte_valid_out <= 1'b0;
            byte_data_out <= ~byte_data_out;
        end
    end
    endtask
endmodule

// *** bench/pdc_regs_properties.sv ***
// checker for the pointer decoder register bank ports
`timescale 1ns/1ns
module pdc_regs_properties
(
    input wire ref_clk_in,
    input wire reset_n_in,
    input wire frame_start_in,
    input wire byte_valid_in,
    input wire [7:0] byte_data_in,
    input wire [3:0] ptr_mode_out,
    input wire [3:0] ptr_sel_out,
    input wire ptr_valid_out,
    input wire mode_unused_out,
    input wire mode_adc_read_out,
    input wire mode_reg_read_out,
    input wire [15:0] reg_read_data_out,
    input wire dac_write_out,
    input wire [7:0] dac_write_mask_out,
    input wire [15:0] dac_write_data_out,
    input wire dac_transfer_out,
    input wire soft_reset_out,
    input wire [3:0] current_boost_out,
    input wire [7:0] pin_voltage_out_en_out,
    input wire [7:0] pin_current_out_en_out,
    input wire [7:0] pin_dac_drive_out,
    input wire [7:0] pin_pulldown_en_out
);
    // ****************************************
    // byte position tracker: 0 pointer, 1 high byte, 2 low byte
    // ****************************************
    reg [1:0] cnt;
    reg [7:0] msb;
    wire take = byte_valid_in && !frame_start_in && !soft_reset_out;
    always @(posedge ref_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt <= 2'd0;
            msb <= 8'h00;
        end
        else if (frame_start_in || soft_reset_out)
            cnt <= 2'd0;
        else if (byte_valid_in)
        begin
            cnt <= (cnt == 2'd1) ? 2'd2 : 2'd1;
            if (cnt == 2'd1)
                msb <= byte_data_in;
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!reset_n_in);
    ptr_capture_a: assert property (take && cnt == 2'd0 |=> ptr_valid_out && {ptr_mode_out, ptr_sel_out} == $past(byte_data_in))
        else $error("pointer not captured");
    dac_word_a: assert property (take && cnt == 2'd2 && ptr_mode_out == 4'h1 |=> dac_write_out && dac_write_data_out == {msb, $past(byte_data_in)})
        else $error("dac word wrong");
    dac_mask_a: assert property (dac_write_out |-> dac_write_mask_out == 8'hFF || dac_write_mask_out == (8'h01 << ptr_sel_out[2:0]))
        else $error("dac mask wrong");
    no_dac_a: assert property (take && cnt == 2'd2 && ptr_mode_out != 4'h1 |=> !dac_write_out)
        else $error("stray dac write");
    soft_reset_a: assert property (take && cnt == 2'd2 && ptr_mode_out == 4'h0 && ptr_sel_out == 4'hF |=> soft_reset_out ##1 (!soft_reset_out && !ptr_valid_out && pin_pulldown_en_out == 8'hFF))
        else $error("soft reset wrong");
    load_transfer_a: assert property (take && cnt == 2'd2 && ptr_mode_out == 4'h0 && ptr_sel_out == 4'h7 && byte_data_in[1:0] == 2'h2 |=> dac_transfer_out)
        else $error("no transfer pulse");
    cut_short_a: assert property (frame_start_in && cnt == 2'd2 |=> $stable(reg_read_data_out))
        else $error("half word wrote");
    reg_mode_a: assert property (ptr_valid_out && ptr_mode_out == 4'h7 |-> mode_reg_read_out && !mode_unused_out && !mode_adc_read_out)
        else $error("readback mode wrong");
    unused_mode_a: assert property (ptr_valid_out && ptr_mode_out[3:1] == 3'b001 |-> mode_unused_out)
        else $error("unused mode missed");
    current_pins_a: assert property (pin_current_out_en_out[7:4] == 4'h0 && (current_boost_out & ~pin_current_out_en_out[3:0]) == 4'h0)
        else $error("current pins wrong");
    dac_drive_a: assert property (pin_dac_drive_out == (pin_voltage_out_en_out | pin_current_out_en_out) && (pin_pulldown_en_out & pin_dac_drive_out) == 8'h00)
        else $error("pin drive wrong");
endmodule
bind pdc_pointer_decode_config_regs pdc_regs_properties chk (.*);

// *** bench/pointer_decode_config_regs_tb_top.sv ***
// self-checking bench for the pointer decoder register bank
`timescale 1ns/1ns
`include "pdc_defs.vh"
module pointer_decode_config_regs_tb_top;
    reg ref_clk_in = 1'b0;
    reg reset_n_in = 1'b0;
    reg look = 1'b0;
    reg [1:0] look_idx = 2'd0;
    reg [15:0] shadow [0:15];
    reg [31:0] exp_q [$];
    reg [23:0] dac_q [$];
    reg [31:0] r;
    integer seed = 5273;
    integer fail_count = 0;
    integer n_compared = 0;
    integer cycles = 0;
    integer i;
    wire fs, bv, mu, ma, md, mg, mr, dw, ld, lh, ab, ar, dr, pv;
    wire [7:0] bd, dm, pc, pd, pp;
    wire [15:0] rd_data, dd;
    wire [3:0] cb, pm, ps;
    always #5 ref_clk_in = ~ref_clk_in;
    pdc_host_model host (.ref_clk_in(ref_clk_in), .frame_start_out(fs), .byte_valid_out(bv), .byte_data_out(bd));
    pdc_pointer_decode_config_regs uut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in), .frame_start_in(fs),
        .byte_valid_in(bv), .byte_data_in(bd), .ptr_mode_out(pm), .ptr_sel_out(ps), .ptr_valid_out(pv),
        .mode_unused_out(mu), .mode_adc_read_out(ma), .mode_dac_read_out(md), .mode_gpio_read_out(mg),
        .mode_reg_read_out(mr), .reg_read_data_out(rd_data), .dac_write_out(dw), .dac_write_mask_out(dm),
        .dac_write_data_out(dd), .dac_transfer_out(), .dac_load_direct_out(ld), .dac_load_hold_out(lh),
        .soft_reset_out(), .current_boost_out(cb), .adc_sequence_out(), .adc_buffer_en_out(ab),
        .adc_range_double_out(ar), .dac_range_double_out(dr), .powerdown_reference_out(), .pin_adc_en_out(),
        .pin_voltage_out_en_out(), .pin_current_out_en_out(pc), .pin_dac_drive_out(pd), .pin_pulldown_en_out(pp),
        .pin_digital_out_en_out(), .pin_digital_out_data_out(), .pin_digital_in_en_out(), .pin_open_drain_out(),
        .pin_high_impedance_out());
    // ****************************************
    // expectations and checking
    // ****************************************
    task check(input string what, input [31:0] seen, input [31:0] expv);
    begin
        n_compared = n_compared + 1;
        if (seen !== expv)
        begin
            fail_count = fail_count + 1;
            $display("BAD %s expected %h seen %h", what, expv, seen);
        end
    end
    endtask
    task conclude;
    begin
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    end
    endtask
    task clear_shadow;
    begin
        for (i = 0; i < 16; i = i + 1)
            shadow[i] = `PDC_RST_ZERO;
        shadow[6] = `PDC_RST_PULLDOWN;
    end
    endtask
    // reserved bits sent as zero, lock bit left alone
    function [15:0] wmask(input [3:0] o);
    begin
        case (o)
            4'h1: wmask = `PDC_BOOST_MASK;
            4'h2, 4'hB: wmask = 16'hFFFF;
            4'h3: wmask = 16'h0270;
            4'h7: wmask = 16'h0003;
            default: wmask = `PDC_PIN_MASK;
        endcase
    end
    endfunction
    function [31:0] pins_exp(input [3:0] unused);
        reg [7:0] drv;
    begin
        drv = shadow[5][7:0] | {4'h0, shadow[14][3:0]};
        pins_exp = {1'b0, shadow[1][8:5] & shadow[14][3:0], drv, shadow[3][9], shadow[3][5], shadow[3][4],
            shadow[6][7:0] & ~drv & ~shadow[8][7:0], 4'h0, shadow[14][3:0]};
    end
    endfunction
    function [31:0] modes_exp(input [7:0] p);
        reg [3:0] c;
    begin
        c = p[7:4];
        modes_exp = {16'h0, 1'b1, p, !(c <= 4'h1 || (c >= 4'h4 && c <= 4'h7)), c == 4'h4, c == 4'h5, c == 4'h6,
            c == 4'h7, shadow[7][1:0] == 2'h0, shadow[7][1:0] == 2'h1};
    end
    endfunction
    always @(posedge ref_clk_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            fail_count = fail_count + 1;
            conclude();
        end
        if (look)
            case (look_idx)
                2'd0: check("register", {16'h0, rd_data}, exp_q.pop_front());
                2'd1: check("pins", {1'b0, cb, pd, ab, ar, dr, pp, pc}, exp_q.pop_front());
                default: check("modes", {16'h0, pv, pm, ps, mu, ma, md, mg, mr, ld, lh}, exp_q.pop_front());
            endcase
        if (dw)
            check("dac", {8'h0, dm, dd}, {8'h0, dac_q.pop_front()});
    end
    // ****************************************
    // transactions
    // ****************************************
    task wr(input [3:0] o, input [15:0] v);
    begin
        host.frame();
        host.put({`PDC_MODE_CONFIG, o});
        host.word(v);
        host.idle(2);
        if (o == `PDC_OFS_SOFT_RESET)
            clear_shadow();
        else if (o != 4'h0 && !(shadow[3][7] && o >= 4'h4 && o != 4'h7 && o != 4'h9 && o != 4'hB))
            shadow[o] = v;
    end
    endtask
    task probe(input [7:0] ptr, input [1:0] idx, input [31:0] expv);
    begin
        host.frame();
        host.put(ptr);
        host.idle(1);
        exp_q.push_back(expv);
        look_idx <= idx;
        look <= 1'b1;
        @(negedge ref_clk_in);
        look <= 1'b0;
    end
    endtask
    task rd(input [3:0] o);
    begin
        probe({`PDC_MODE_REG_READ, o}, 2'd0, {16'h0, shadow[o]});
    end
    endtask
    task dac_words(input [2:0] ch, input [7:0] m);
    begin
        host.frame();
        host.put({`PDC_MODE_DAC_WRITE, 1'b0, ch});
        repeat (2)
        begin
            r = $random(seed);
            dac_q.push_back({m, r[15:0]});
            host.word(r[15:0]);
        end
        host.idle(2);
    end
    endtask
    initial
    begin
        clear_shadow();
        repeat (10) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        for (i = 0; i < 16; i = i + 1)
            rd(i[3:0]);
        probe(8'h70, 2'd1, pins_exp(4'h0));
        for (i = 1; i < 15; i = i + 1)
        begin
            r = $random(seed);
            wr(i[3:0], r[15:0] & wmask(i[3:0]));
            rd(i[3:0]);
        end
        probe(8'h70, 2'd1, pins_exp(4'h0));
        wr(4'h3, 16'h0080);
        wr(4'h4, ~shadow[4] & `PDC_PIN_MASK);
        rd(4'h4);
        wr(4'h3, 16'h0270);
        probe(8'h70, 2'd1, pins_exp(4'h0));
        dac_words(3'd5, 8'hFF);
        wr(4'h3, 16'h0000);
        for (i = 0; i < 8; i = i + 1)
            dac_words(i[2:0], 8'h01 << i);
        host.frame();
        host.put(8'h05);
        host.put(8'hAA);
        host.frame();
        host.idle(1);
        rd(4'h5);
        for (i = 0; i < 4; i = i + 1)
        begin
            wr(4'h7, i[15:0]);
            probe(8'h77, 2'd2, modes_exp(8'h77));
        end
        for (i = 0; i < 16; i = i + 1)
            probe({i[3:0], 4'h3}, 2'd2, modes_exp({i[3:0], 4'h3}));
        wr(`PDC_OFS_SOFT_RESET, 16'h0000);
        rd(4'h6);
        rd(4'h1);
        wr(4'h2, 16'h1234);
        reset_n_in = 1'b0;
        clear_shadow();
        repeat (3) @(negedge ref_clk_in);
        reset_n_in = 1'b1;
        rd(4'h2);
        probe(8'h70, 2'd1, pins_exp(4'h0));
        repeat (3) @(negedge ref_clk_in);
        conclude();
    end
endmodule
